/* File: hw/qps_pkg.sv */
// Constants, opcodes and carrier types for the quad page program and suspend block.
// Assumes the sequencer runs on a fast core clock that oversamples the serial clock.
package qps_pkg;

  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_HALT_PENDING_FLAG_A = 8'h75;
  localparam logic [7:0] OP_HALT_PENDING_FLAG_B = 8'hB0;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_RD_03 = 8'h03;
  localparam logic [7:0] OP_RD_0B = 8'h0B;
  localparam logic [7:0] OP_RD_3B = 8'h3B;
  localparam logic [7:0] OP_RD_6B = 8'h6B;
  localparam logic [7:0] OP_RD_EB = 8'hEB;
  localparam logic [7:0] OP_RD_E7 = 8'hE7;
  localparam logic [7:0] OP_BE_20 = 8'h20;
  localparam logic [7:0] OP_BE_52 = 8'h52;
  localparam logic [7:0] OP_BE_D8 = 8'hD8;
  localparam logic [7:0] OP_CE_60 = 8'h60;
  localparam logic [7:0] OP_CE_C7 = 8'hC7;
  localparam logic [7:0] OP_PP_02 = 8'h02;
  localparam logic [7:0] OP_PP_A2 = 8'hA2;
  localparam logic [7:0] OP_SEQ_AD = 8'hAD;
  localparam logic [7:0] OP_SEQ_AF = 8'hAF;

  localparam logic [4:0] OPC_LAST_BIT = 5'h07;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  localparam int PAGE_BYTES = 256;
  localparam int FIFO_DEPTH = 16;
  localparam int ARR_WIDTH = 32;

  // Pin order inside the synchronised bundle.
  localparam int PIN_SI = 0;
  localparam int PIN_SO = 1;
  localparam int PIN_WP = 2;
  localparam int PIN_HOLD = 3;
  localparam int PIN_SCLK = 4;
  localparam int PIN_CS = 5;
  localparam logic [5:0] PIN_RESET = 6'h3F;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPC = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_HALT_PENDING_FLAG = 3'b100,
    ST_WREN = 3'b101,
    ST_SKIP = 3'b110
  } qps_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] data;
  } qps_arr_word_t;

  typedef struct packed {
    logic busy_flag;
    logic write_latch_armed;
    logic halt_pending_flag;
    logic program_suspended_flag;
    logic erase_suspended_flag;
    logic program_fail_flag;
    logic erase_fail_flag;
  } qps_status_t;

  localparam qps_status_t STATUS_RESET = 7'h00;

endpackage : qps_pkg

/* File: hw/qps_fifo.sv */
// Flop-based FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
module qps_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : qps_fifo

/* File: hw/qps_seq.sv */
// Serial command sequencer: quad page program and program/erase suspend.
// Assumes all pins are asynchronous to clock and the serial clock is at least four times slower.
`timescale 1ns/1ps
module qps_seq (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_mode_allow,
  input wire logic region_protected,
  input wire logic erase_running,
  input wire logic [7:0] erase_block,
  input wire logic resume_req,
  input wire logic arr_fail,
  input wire logic fail_clear,
  output logic [23:0] page_addr,
  output logic arr_valid,
  input wire logic arr_ready,
  output qps_pkg::qps_arr_word_t arr_word,
  output logic erase_halt,
  output logic cmd_pass,
  output logic [7:0] cmd_code,
  output qps_pkg::qps_status_t status
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_s3_q;
  wire [5:0] pin_raw = {cs_n, sclk, io_in};

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1_q <= qps_pkg::PIN_RESET;
      pin_s2_q <= qps_pkg::PIN_RESET;
      pin_s3_q <= qps_pkg::PIN_RESET;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire sclk_rise = pin_s2_q[qps_pkg::PIN_SCLK] && !pin_s3_q[qps_pkg::PIN_SCLK];
  wire cs_fall = !pin_s2_q[qps_pkg::PIN_CS] && pin_s3_q[qps_pkg::PIN_CS];
  wire cs_rise = pin_s2_q[qps_pkg::PIN_CS] && !pin_s3_q[qps_pkg::PIN_CS];
  wire cs_low = !pin_s2_q[qps_pkg::PIN_CS];
  wire bit_si = pin_s2_q[qps_pkg::PIN_SI];
  wire [3:0] nibble = pin_s2_q[3:0];

  // ----------------------------------------------------------------
  // Command permission
  // ----------------------------------------------------------------
  qps_pkg::qps_status_t st_q;

  // Returns one when the opcode may run in the present busy/suspend state.
  function automatic logic op_allowed(input logic [7:0] op, input qps_pkg::qps_status_t s);
    logic is_read;
    logic is_erase;
    logic is_prog;
    logic is_halt_pending_flag;
    logic ok;
    is_read = (op == qps_pkg::OP_RD_03) || (op == qps_pkg::OP_RD_0B) || (op == qps_pkg::OP_RD_3B) ||
              (op == qps_pkg::OP_RD_6B) || (op == qps_pkg::OP_RD_EB) || (op == qps_pkg::OP_RD_E7);
    is_erase = (op == qps_pkg::OP_BE_20) || (op == qps_pkg::OP_BE_52) || (op == qps_pkg::OP_BE_D8) ||
               (op == qps_pkg::OP_CE_60) || (op == qps_pkg::OP_CE_C7);
    is_prog = (op == qps_pkg::OP_PP_02) || (op == qps_pkg::OP_PP_A2) || (op == qps_pkg::OP_QUAD_PROG) ||
              (op == qps_pkg::OP_SEQ_AD) || (op == qps_pkg::OP_SEQ_AF);
    is_halt_pending_flag = (op == qps_pkg::OP_HALT_PENDING_FLAG_A) || (op == qps_pkg::OP_HALT_PENDING_FLAG_B);
    ok = 1'b1;
    if (s.busy_flag) begin
      ok = is_halt_pending_flag;
      if (!is_halt_pending_flag && !is_read && !is_erase && !is_prog) begin
        ok = (op != qps_pkg::OP_WR_EN);
      end
    end else if (s.program_suspended_flag) begin
      ok = !(is_erase || is_prog || is_halt_pending_flag);
    end else if (s.erase_suspended_flag) begin
      ok = !(is_erase || is_halt_pending_flag);
    end else begin
      ok = !is_halt_pending_flag;
    end
    return ok;
  endfunction : op_allowed

  // ----------------------------------------------------------------
  // Serial front end
  // ----------------------------------------------------------------
  qps_pkg::qps_state_t state_q;
  qps_pkg::qps_state_t state_d;
  logic [4:0] bit_cnt_q;
  logic [6:0] op_sh_q;
  logic [23:0] addr_q;
  logic [7:0] off_q;
  logic [3:0] hi_nib_q;
  logic second_nib_q;
  logic got_byte_q;

  wire [7:0] opcode = {op_sh_q, bit_si};
  wire opc_done = (state_q == qps_pkg::ST_OPC) && sclk_rise && (bit_cnt_q == qps_pkg::OPC_LAST_BIT);
  wire op_ok = op_allowed(opcode, st_q);
  wire is_qprog = (opcode == qps_pkg::OP_QUAD_PROG);
  wire is_halt_pending_flag_op = (opcode == qps_pkg::OP_HALT_PENDING_FLAG_A) || (opcode == qps_pkg::OP_HALT_PENDING_FLAG_B);
  wire prog_ready = st_q.write_latch_armed && quad_mode_allow;
  wire addr_done = (state_q == qps_pkg::ST_ADDR) && sclk_rise && (bit_cnt_q == qps_pkg::ADDR_LAST_BIT);
  wire byte_done = (state_q == qps_pkg::ST_DATA) && sclk_rise && second_nib_q;
  wire [7:0] rx_byte = {hi_nib_q, nibble};
  wire whole_bytes = !second_nib_q && got_byte_q;
  wire blk_hit = st_q.erase_suspended_flag && (addr_q[23:16] == erase_block);
  wire start_prog = cs_rise && (state_q == qps_pkg::ST_DATA) && whole_bytes && !region_protected && !blk_hit;
  wire abort_xfer = cs_rise && ((state_q == qps_pkg::ST_ADDR) ||
                    ((state_q == qps_pkg::ST_DATA) && !whole_bytes));
  wire prot_skip = cs_rise && (state_q == qps_pkg::ST_DATA) && whole_bytes && region_protected;
  wire do_halt_pending_flag = cs_rise && (state_q == qps_pkg::ST_HALT_PENDING_FLAG);
  wire do_wren = cs_rise && (state_q == qps_pkg::ST_WREN);

  always_comb begin
    state_d = state_q;
    if (cs_rise || !cs_low) begin
      state_d = qps_pkg::ST_IDLE;
    end else if (cs_fall) begin
      state_d = qps_pkg::ST_OPC;
    end else if (opc_done) begin
      state_d = qps_pkg::ST_SKIP;
      if (!op_ok) begin
        state_d = qps_pkg::ST_SKIP;
      end else if (is_qprog && prog_ready) begin
        state_d = qps_pkg::ST_ADDR;
      end else if (is_halt_pending_flag_op) begin
        state_d = qps_pkg::ST_HALT_PENDING_FLAG;
      end else if (opcode == qps_pkg::OP_WR_EN) begin
        state_d = qps_pkg::ST_WREN;
      end
    end else if (addr_done) begin
      state_d = qps_pkg::ST_DATA;
    end else if ((state_q == qps_pkg::ST_HALT_PENDING_FLAG || state_q == qps_pkg::ST_WREN) && sclk_rise) begin
      state_d = qps_pkg::ST_SKIP;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= qps_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || cs_fall) begin
      bit_cnt_q <= '0;
      op_sh_q <= '0;
    end else if (sclk_rise && (state_q == qps_pkg::ST_OPC || state_q == qps_pkg::ST_ADDR)) begin
      bit_cnt_q <= opc_done ? 5'h00 : bit_cnt_q + 5'h01;
      op_sh_q <= {op_sh_q[5:0], bit_si};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addr_q <= '0;
    end else if (sclk_rise && state_q == qps_pkg::ST_ADDR) begin
      addr_q <= {addr_q[22:0], bit_si};
    end
  end

  always_ff @(posedge clock) begin
    if (rst || opc_done) begin
      second_nib_q <= 1'b0;
      got_byte_q <= 1'b0;
      hi_nib_q <= '0;
    end else if (sclk_rise && state_q == qps_pkg::ST_DATA) begin
      second_nib_q <= !second_nib_q;
      hi_nib_q <= second_nib_q ? hi_nib_q : nibble;
      got_byte_q <= got_byte_q || second_nib_q;
    end
  end

  // Only the low byte moves; the page bits of the start address never change.
  always_ff @(posedge clock) begin
    if (rst) begin
      off_q <= '0;
    end else if (addr_done) begin
      off_q <= {addr_q[6:0], bit_si};
    end else if (byte_done) begin
      off_q <= off_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  // Writing by page offset means a later lap overwrites an earlier one, so the
  // buffer holds only the final 256 bytes.
  logic run_q;
  wire busy_engine = run_q;
  logic [7:0] buf_q [qps_pkg::PAGE_BYTES];
  logic [qps_pkg::PAGE_BYTES-1:0] wmask_q;

  for (genvar i = 0; i < qps_pkg::PAGE_BYTES; i++) begin : g_page
    always_ff @(posedge clock) begin
      if (rst) begin
        buf_q[i] <= '0;
        wmask_q[i] <= 1'b0;
      end else if (opc_done && !busy_engine) begin
        wmask_q[i] <= 1'b0;
      end else if (byte_done && off_q == 8'(i)) begin
        buf_q[i] <= rx_byte;
        wmask_q[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program engine
  // ----------------------------------------------------------------
  logic [8:0] walk_q;
  logic [23:0] page_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  qps_pkg::qps_arr_word_t fifo_out;
  wire walking = run_q && !walk_q[8] && !st_q.program_suspended_flag;
  wire want_push = walking && wmask_q[walk_q[7:0]];
  wire advance = walking && (!wmask_q[walk_q[7:0]] || fifo_in_ready);
  wire load_out = fifo_out_valid && (!arr_valid || arr_ready);
  wire prog_done = run_q && walk_q[8] && !fifo_out_valid && !arr_valid;
  qps_pkg::qps_arr_word_t push_word;

  assign push_word = '{addr: {page_q[23:8], walk_q[7:0]}, data: buf_q[walk_q[7:0]]};

  always_ff @(posedge clock) begin
    if (rst) begin
      run_q <= 1'b0;
      walk_q <= '0;
      page_q <= '0;
    end else if (start_prog) begin
      run_q <= 1'b1;
      walk_q <= '0;
      page_q <= {addr_q[23:8], 8'h00};
    end else if (prog_done) begin
      run_q <= 1'b0;
    end else if (advance) begin
      walk_q <= walk_q + 9'h001;
    end
  end

  qps_fifo #(
    .WIDTH(qps_pkg::ARR_WIDTH),
    .DEPTH(qps_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(want_push),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(load_out),
    .out_data(fifo_out)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      arr_valid <= 1'b0;
      arr_word <= '0;
    end else if (load_out) begin
      arr_valid <= 1'b1;
      arr_word <= fifo_out;
    end else if (arr_ready) begin
      arr_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  wire halt_pending_flag_prog = do_halt_pending_flag && run_q;
  wire halt_pending_flag_erase = do_halt_pending_flag && !run_q && erase_running;

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= qps_pkg::STATUS_RESET;
    end else begin
      // Busy covers our own programming and the external erase engine.
      st_q.busy_flag <= (run_q && !prog_done && !st_q.program_suspended_flag && !halt_pending_flag_prog) ||
                        start_prog ||
                        (erase_running && !st_q.erase_suspended_flag && !halt_pending_flag_erase);
      if (do_wren) begin
        st_q.write_latch_armed <= 1'b1;
      end else if (abort_xfer || prog_done || prot_skip) begin
        st_q.write_latch_armed <= 1'b0;
      end
      if (halt_pending_flag_prog) begin
        st_q.program_suspended_flag <= 1'b1;
      end else if (resume_req) begin
        st_q.program_suspended_flag <= 1'b0;
      end
      if (halt_pending_flag_erase) begin
        st_q.erase_suspended_flag <= 1'b1;
      end else if (resume_req && !st_q.program_suspended_flag) begin
        st_q.erase_suspended_flag <= 1'b0;
      end
      if (halt_pending_flag_prog || halt_pending_flag_erase) begin
        st_q.halt_pending_flag <= 1'b1;
      end else if (resume_req) begin
        st_q.halt_pending_flag <= st_q.program_suspended_flag && st_q.erase_suspended_flag;
      end
      // A failure in the same cycle as a clear is kept.
      if (arr_fail && run_q) begin
        st_q.program_fail_flag <= 1'b1;
        st_q.erase_fail_flag <= 1'b1;
      end else if (fail_clear) begin
        st_q.program_fail_flag <= 1'b0;
        st_q.erase_fail_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      io_out <= '0;
      io_oe <= '0;
      cmd_pass <= 1'b0;
      cmd_code <= '0;
      erase_halt <= 1'b0;
      page_addr <= '0;
      status <= qps_pkg::STATUS_RESET;
    end else begin
      io_out <= '0;
      // The serial-out line is only ours while opcode and address come in.
      io_oe <= {2'b00, (state_d == qps_pkg::ST_OPC || state_d == qps_pkg::ST_ADDR), 1'b0};
      cmd_pass <= opc_done && op_ok && !is_qprog && !is_halt_pending_flag_op && (opcode != qps_pkg::OP_WR_EN);
      cmd_code <= opc_done ? opcode : cmd_code;
      erase_halt <= st_q.erase_suspended_flag;
      page_addr <= page_q;
      status <= st_q;
    end
  end

endmodule : qps_seq

/* File: test/qps_host.sv */
// Behavioural SPI host that drives chip select, serial clock and the four I/O lines.
// Assumes the bench clock runs at 125 MHz; one serial clock period is eight core cycles.
`timescale 1ns/1ps
module qps_host (
  input wire logic clock,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] h_io
);
  // ----------------------------------------
  // Frame generation
  // ----------------------------------------
  logic [7:0] dbuf [0:299];

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    h_io = 4'b1100;
  end

  // Data changes while the serial clock is low, so the device samples it on the rise.
  task automatic tick(input logic [3:0] v);
    h_io <= v;
    sclk <= 1'b0;
    repeat (4) @(posedge clock);
    sclk <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : tick

  task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input int nadr, input int nnib);
    logic [3:0] nib;
    @(posedge clock);
    cs_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 7; i >= 0; i--) tick({3'b111, opc[i]});
    for (int i = 23; i >= 24 - nadr; i--) tick({3'b111, adr[i]});
    for (int k = 0; k < nnib; k++) begin
      nib = k[0] ? dbuf[k / 2][3:0] : dbuf[k / 2][7:4];
      tick(nib);
    end
    sclk <= 1'b0;
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    // Released lines must not keep showing the last value.
    h_io <= ~h_io;
    repeat (12) @(posedge clock);
  endtask : frame
endmodule : qps_host

/* File: test/qps_seq_properties.sv */
// Concurrent checks on the ports of the quad program and suspend sequencer.
// Assumes a single core clock domain with synchronous active-high reset.
`timescale 1ns/1ps
module qps_seq_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic [23:0] page_addr,
  input wire logic arr_valid,
  input wire logic arr_ready,
  input wire qps_pkg::qps_arr_word_t arr_word,
  input wire logic erase_halt,
  input wire qps_pkg::qps_status_t status
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_stall;
    arr_valid && !arr_ready;
  endsequence

  sequence s_busy_end;
    $fell(status.busy_flag);
  endsequence

  chk_oe_so_only: assert property (io_out == 4'h0 && io_oe[3:2] == 2'b00 && !io_oe[0])
    else $error("only the serial-out line may be driven");
  chk_oe_idle: assert property (cs_n [*5] |-> !io_oe[1])
    else $error("serial-out driven outside a frame");
  chk_stream_hold: assert property (s_stall |=> arr_valid && $stable(arr_word))
    else $error("array word changed while stalled");
  chk_done_clears_wel: assert property (s_busy_end |-> ##1 (!status.write_latch_armed ||
    status.program_suspended_flag || status.erase_suspended_flag))
    else $error("write latch still armed after program end");
  chk_halt_mirror: assert property (erase_halt == status.erase_suspended_flag)
    else $error("erase halt does not follow erase suspended flag");
  chk_fail_pair: assert property (status.program_fail_flag == status.erase_fail_flag)
    else $error("fail flags differ");
  chk_suspend_flags: assert property ($rose(status.program_suspended_flag) ||
    $rose(status.erase_suspended_flag) |-> !status.busy_flag && status.halt_pending_flag)
    else $error("suspend did not clear busy or set halt pending");
  chk_page_base: assert property (arr_valid |-> arr_word.addr[23:8] == page_addr[23:8])
    else $error("array word outside the page");
endmodule : qps_seq_properties

bind qps_seq qps_seq_properties chk (.clock(clock), .rst(rst), .cs_n(cs_n), .io_out(io_out), .io_oe(io_oe),
  .page_addr(page_addr), .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_word(arr_word),
  .erase_halt(erase_halt), .status(status));

/* File: test/qps_seq_test.sv */
// Self-checking bench for the quad program and suspend sequencer.
// Assumes the package, the design, the host model and the checker are compiled first.
`timescale 1ns/1ps
module qps_seq_test;
  // ----------------------------------------
  // Environment
  // ----------------------------------------
  logic clock, rst, qmode, prot, erun, rsm, afail, fclr, ardy, hold_rdy, arr_valid, erase_halt, cmd_pass;
  logic cs_n, sclk;
  logic [3:0] h_io, io_in, io_out, io_oe;
  logic [7:0] eblk, ccode;
  logic [23:0] page_addr, a;
  qps_pkg::qps_arr_word_t arr_word;
  qps_pkg::qps_status_t status;
  qps_pkg::qps_arr_word_t got [$];
  int fail_count, n_tests, npass, np;
  logic [7:0] ops [2] = '{qps_pkg::OP_HALT_PENDING_FLAG_A, qps_pkg::OP_HALT_PENDING_FLAG_B};

  assign io_in = (io_oe & io_out) | (~io_oe & h_io);

  qps_seq dut (.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .quad_mode_allow(qmode), .region_protected(prot), .erase_running(erun),
    .erase_block(eblk), .resume_req(rsm), .arr_fail(afail), .fail_clear(fclr), .page_addr(page_addr),
    .arr_valid(arr_valid), .arr_ready(ardy), .arr_word(arr_word), .erase_halt(erase_halt),
    .cmd_pass(cmd_pass), .cmd_code(ccode), .status(status));
  qps_host host (.clock(clock), .cs_n(cs_n), .sclk(sclk), .h_io(h_io));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // The array side stalls at random so the FIFO is exercised under backpressure.
  always @(posedge clock) begin
    ardy <= hold_rdy ? 1'b0 : ($urandom % 4 != 0);
    if (arr_valid && ardy) got.push_back(arr_word);
    if (cmd_pass) npass++;
  end

  function automatic int last_idx(input logic [7:0] start, input int n, input int off);
    for (int i = n - 1; i >= 0; i--) if ((start + i) % 256 == off) return i;
    return -1;
  endfunction : last_idx

  task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
    n_tests++;
    if (got_v !== exp_v) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : check

  // One-cycle strobe: 0 raises the array failure, 1 the fail clear, 2 the resume request.
  task automatic pulse(input int sel);
    afail <= (sel == 0);
    fclr <= (sel == 1);
    rsm <= (sel == 2);
    @(posedge clock);
    afail <= 1'b0;
    fclr <= 1'b0;
    rsm <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : pulse

  task automatic wait_idle();
    for (int t = 0; t < 4000 && status.busy_flag !== 1'b0; t++) @(posedge clock);
  endtask : wait_idle

  task automatic prog(input logic [23:0] adr, input int n);
    int j;
    int idx;
    got.delete();
    j = 0;
    for (int i = 0; i < 300; i++) host.dbuf[i] = 8'($urandom);
    host.frame(qps_pkg::OP_WR_EN, 24'h00_0000, 0, 0);
    host.frame(qps_pkg::OP_QUAD_PROG, adr, 24, 2 * n);
    wait_idle();
    for (int off = 0; off < 256; off++) begin
      idx = last_idx(adr[7:0], n, off);
      if (idx >= 0 && j < got.size()) check(got[j], {adr[23:8], 8'(off), host.dbuf[idx]});
      if (idx >= 0) j++;
    end
    check(got.size(), j);
    check({status.busy_flag, status.write_latch_armed}, 2'b00);
    check(page_addr, {adr[23:8], 8'h00});
  endtask : prog

  task automatic try_prog(input logic wren, input int nadr, input int nnib, input logic exp_wel);
    got.delete();
    if (wren) host.frame(qps_pkg::OP_WR_EN, 24'h00_0000, 0, 0);
    host.frame(qps_pkg::OP_QUAD_PROG, 24'h12_3400, nadr, nnib);
    repeat (40) @(posedge clock);
    check(got.size(), 0);
    check(status.write_latch_armed, exp_wel);
  endtask : try_prog

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (80000) @(posedge clock);
    fail_count++;
    summarize();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(89));
    rst = 1'b1;
    qmode = 1'b1;
    prot = 1'b0;
    erun = 1'b0;
    rsm = 1'b0;
    afail = 1'b0;
    fclr = 1'b0;
    hold_rdy = 1'b0;
    eblk = 8'h5A;
    fail_count = 0;
    n_tests = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check(status, qps_pkg::STATUS_RESET);
    a = 24'($urandom);
    a[7:0] = 8'hFE;
    prog(a, 3);
    a = 24'($urandom);
    prog(a, 1 + $urandom % 40);
    a[7:0] = 8'h10;
    prog(a, 300);
    try_prog(1'b0, 24, 2, 1'b0);
    try_prog(1'b1, 12, 0, 1'b0);
    try_prog(1'b1, 24, 3, 1'b0);
    try_prog(1'b1, 24, 0, 1'b0);
    prot <= 1'b1;
    try_prog(1'b1, 24, 2, 1'b0);
    prot <= 1'b0;
    qmode <= 1'b0;
    try_prog(1'b1, 24, 2, 1'b1);
    qmode <= 1'b1;
    foreach (ops[k]) begin
      got.delete();
      hold_rdy <= 1'b1;
      host.frame(qps_pkg::OP_WR_EN, 24'h00_0000, 0, 0);
      host.frame(qps_pkg::OP_QUAD_PROG, a, 24, 2);
      check(status.busy_flag, 1'b1);
      pulse(0);
      check({status.program_fail_flag, status.erase_fail_flag}, 2'b11);
      pulse(1);
      check(status.program_fail_flag, 1'b0);
      np = npass;
      host.frame(qps_pkg::OP_RD_03, 24'h00_0000, 0, 0);
      check(npass, np);
      host.frame(ops[k], 24'h00_0000, 0, 0);
      check({status.busy_flag, status.halt_pending_flag, status.program_suspended_flag}, 3'b011);
      host.frame(qps_pkg::OP_BE_20, 24'h00_0000, 0, 0);
      check(npass, np);
      host.frame(qps_pkg::OP_RD_03, 24'h00_0000, 0, 0);
      check(npass, np + 1);
      check(ccode, qps_pkg::OP_RD_03);
      pulse(2);
      hold_rdy <= 1'b0;
      wait_idle();
      check({got.size() == 1, status.program_suspended_flag}, 2'b10);
    end
    erun <= 1'b1;
    repeat (4) @(posedge clock);
    check(status.busy_flag, 1'b1);
    host.frame(qps_pkg::OP_HALT_PENDING_FLAG_B, 24'h00_0000, 0, 0);
    check({status.program_suspended_flag, status.erase_suspended_flag, erase_halt}, 3'b011);
    got.delete();
    host.frame(qps_pkg::OP_WR_EN, 24'h00_0000, 0, 0);
    host.frame(qps_pkg::OP_QUAD_PROG, {eblk, 16'h0000}, 24, 2);
    repeat (40) @(posedge clock);
    check({got.size() == 0, status.write_latch_armed}, 2'b11);
    prog({8'h33, 16'h1200}, 2);
    check(status.erase_suspended_flag, 1'b1);
    pulse(2);
    erun <= 1'b0;
    summarize();
  end
endmodule : qps_seq_test
